// ### hdl/lns_pkg.sv
// What this block does
// R1 - Role bit six selects master or slave
// R2 - Masters always use manual bit-rate factors
// R3 - Bit five selects manual or automatic rate
// R4 - Other registers reached via address/data pair
// R5 - Rate is clock over prescale, divider, multiplier
// R6 - Prescaler 0-3, multiplier 0-31, divider 200-511
// R7 - Automatic mode: prescale and divider give 20 kHz
// R8 - Classic or enhanced checksum computed in hardware
// R9 - Full status readable, interrupt or polled
// R10 - Software truncates all factor results downward
package lns_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  // Direct offsets
  localparam logic [1:0] OFS_CTRL = 2'h0;
  localparam logic [1:0] OFS_IADR = 2'h1;
  localparam logic [1:0] OFS_IDAT = 2'h2;
  // Control mode fields
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_ROLE_BIT = 6;
  localparam int CTRL_AUTO_BIT = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Indirect indexes
  localparam logic [7:0] IX_DIV   = 8'h00;
  localparam logic [7:0] IX_MUL   = 8'h01;
  localparam logic [7:0] IX_CKCTL = 8'h02;
  localparam logic [7:0] IX_CKID  = 8'h03;
  localparam logic [7:0] IX_CKDAT = 8'h04;
  localparam logic [7:0] IX_CKCHK = 8'h05;
  localparam logic [7:0] IX_STAT  = 8'h06;
  localparam logic [7:0] IX_MASK  = 8'h07;
  localparam logic [7:0] IX_MEAS  = 8'h08;
  // Multiplier register fields
  localparam int MUL_PRE_LSB = 6;
  localparam int MUL_MUL_LSB = 1;
  localparam int MUL_DIV8    = 0;
  // Checksum control fields
  localparam int CK_ENH_BIT = 0;
  localparam int CK_RST_BIT = 1;
  // Status bits
  localparam int ST_RATE_BIT = 0;
  localparam int ST_CKOK_BIT = 1;
  localparam int ST_CKER_BIT = 2;
  localparam int ST_W = 3;
  // Factor limits and reset values
  localparam logic [8:0] DIV_MIN = 9'h0C8;
  localparam logic [8:0] DIV_RST = 9'h0C8;
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [4:0] MUL_RST = 5'h00;
  localparam logic [7:0] CK_SEED = 8'h00;
  localparam logic [7:0] CK_GOOD = 8'hFF;
  localparam int MEAS_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } lns_bus_req_t;

  typedef struct packed {
    logic       enh;
    logic [7:0] sum;
  } lns_cks_t;
endpackage : lns_pkg

// ### hdl/lns_node.sv
`timescale 1ns/100ps
module lns_node
  import lns_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire lns_bus_req_t      bus_in,
  output logic [DATA_W-1:0]      rd_data_out,
  input  wire logic              lin_rx_in,
  output logic                   bit_tick_out,
  output logic                   ref_tick_out,
  output logic                   master_role_out,
  output logic                   irq_out
);

  typedef enum logic [2:0] {
    MS_IDLE  = 3'b001,
    MS_ARM   = 3'b010,
    MS_COUNT = 3'b100
  } lns_meas_t;

  logic [7:0]        ctrl;
  logic [7:0]        iadr;
  logic [8:0]        divider;
  logic [1:0]        prescale;
  logic [4:0]        multiplier;
  logic [3:0]        pre_cnt;
  logic [8:0]        div_cnt;
  logic [4:0]        mul_cnt;
  logic [4:0]        meas_mul;
  logic [MEAS_W-1:0] meas_cnt;
  lns_meas_t         meas_st;
  lns_cks_t          cks;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   mask;
  logic              rx_s1;
  logic              rx_s2;
  logic              rx_d;
  logic              ref_tick;
  logic              bit_tick;
  logic              auto_act;
  logic              rx_fall;
  logic              wr_ind;
  logic [ST_W-1:0]   ev;
  logic [7:0]        next_rd;
  logic [7:0]        ind_rd;
  logic [4:0]        mul_eff;

  function automatic logic [3:0] pre_last(input logic [1:0] p);
    pre_last = (4'h2 << p) - 4'h1;
  endfunction : pre_last

  function automatic logic [7:0] cks_add(input logic [7:0] s,
                                         input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    cks_add = t[7:0] + {7'h00, t[8]};
  endfunction : cks_add

  function automatic logic [8:0] div_clamp(input logic [8:0] d);
    div_clamp = (d < DIV_MIN) ? DIV_MIN : d;
  endfunction : div_clamp

  assign wr_ind = bus_in.wr && (bus_in.addr == OFS_IDAT);
  // R2 auto slave only
  assign auto_act = ctrl[CTRL_AUTO_BIT] && !ctrl[CTRL_ROLE_BIT];
  assign mul_eff  = auto_act ? meas_mul : multiplier;
  assign rx_fall  = rx_d && !rx_s2;

  // Direct registers
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= CTRL_RST;
      iadr <= 8'h00;
    end else if (bus_in.wr) begin
      // R1 R3 role and rate select
      if (bus_in.addr == OFS_CTRL)
        ctrl <= bus_in.wdata;
      // R4 indirect address
      if (bus_in.addr == OFS_IADR)
        iadr <= bus_in.wdata;
    end
  end

  // R6 factor storage
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      divider    <= DIV_RST;
      prescale   <= PRE_RST;
      multiplier <= MUL_RST;
    end else if (wr_ind && iadr == IX_DIV) begin
      divider <= div_clamp({divider[8], bus_in.wdata});
    end else if (wr_ind && iadr == IX_MUL) begin
      prescale   <= bus_in.wdata[MUL_PRE_LSB +: 2];
      multiplier <= bus_in.wdata[MUL_MUL_LSB +: 5];
      divider    <= div_clamp({bus_in.wdata[MUL_DIV8], divider[7:0]});
    end
  end

  // R5 prescale then divide
  assign ref_tick = ctrl[CTRL_EN_BIT] && pre_cnt == pre_last(prescale)
                    && div_cnt == divider - 9'h001;
  assign bit_tick = ref_tick && mul_cnt == mul_eff;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt <= 4'h0;
      div_cnt <= 9'h000;
      mul_cnt <= 5'h00;
    end else if (!ctrl[CTRL_EN_BIT]) begin
      pre_cnt <= 4'h0;
      div_cnt <= 9'h000;
      mul_cnt <= 5'h00;
    end else if (pre_cnt >= pre_last(prescale)) begin
      pre_cnt <= 4'h0;
      // R5 divider and multiplier
      if (div_cnt >= divider - 9'h001) begin
        div_cnt <= 9'h000;
        mul_cnt <= (mul_cnt >= mul_eff) ? 5'h00 : mul_cnt + 5'h01;
      end else begin
        div_cnt <= div_cnt + 9'h001;
      end
    end else begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_tick_out <= 1'b0;
      ref_tick_out <= 1'b0;
    end else begin
      bit_tick_out <= bit_tick;
      ref_tick_out <= ref_tick;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_d  <= 1'b1;
    end else begin
      rx_s1 <= lin_rx_in;
      rx_s2 <= rx_s1;
      rx_d  <= rx_s2;
    end
  end

  // R7 measure sync in 20 kHz ticks
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meas_st  <= MS_IDLE;
      meas_cnt <= '0;
      meas_mul <= MUL_RST;
    end else begin
      case (meas_st)
        MS_IDLE: begin
          if (auto_act && ctrl[CTRL_EN_BIT])
            meas_st <= MS_ARM;
        end
        MS_ARM: begin
          meas_cnt <= '0;
          if (!auto_act)
            meas_st <= MS_IDLE;
          else if (rx_fall)
            meas_st <= MS_COUNT;
        end
        MS_COUNT: begin
          if (!auto_act) begin
            meas_st <= MS_IDLE;
          end else if (rx_fall) begin
            meas_mul <= (meas_cnt < 8'h04) ? 5'h00
                        : 5'((meas_cnt >> 1) - 8'h01);
            meas_st  <= MS_ARM;
          end else if (ref_tick && meas_cnt != 8'hFF) begin
            meas_cnt <= meas_cnt + 8'h01;
          end
        end
        default: meas_st <= MS_IDLE;
      endcase
    end
  end

  // R8 checksum engine
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cks <= '{enh: 1'b0, sum: CK_SEED};
    end else if (wr_ind && iadr == IX_CKCTL) begin
      cks.enh <= bus_in.wdata[CK_ENH_BIT];
      if (bus_in.wdata[CK_RST_BIT])
        cks.sum <= CK_SEED;
    end else if (wr_ind && iadr == IX_CKID && cks.enh) begin
      cks.sum <= cks_add(cks.sum, bus_in.wdata);
    end else if (wr_ind && iadr == IX_CKDAT) begin
      cks.sum <= cks_add(cks.sum, bus_in.wdata);
    end
  end

  always_comb begin
    ev = '0;
    ev[ST_RATE_BIT] = meas_st == MS_COUNT && auto_act && rx_fall;
    if (wr_ind && iadr == IX_CKCHK) begin
      ev[ST_CKOK_BIT] = cks_add(cks.sum, bus_in.wdata) == CK_GOOD;
      ev[ST_CKER_BIT] = cks_add(cks.sum, bus_in.wdata) != CK_GOOD;
    end
  end

  // R9 sticky status, set wins
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status <= '0;
      mask   <= '0;
    end else begin
      if (wr_ind && iadr == IX_STAT)
        status <= (status & ~bus_in.wdata[ST_W-1:0]) | ev;
      else
        status <= status | ev;
      if (wr_ind && iadr == IX_MASK)
        mask <= bus_in.wdata[ST_W-1:0];
    end
  end

  assign irq_out         = |(status & mask);
  assign master_role_out = ctrl[CTRL_ROLE_BIT];

  // R4 indirect read decode
  always_comb begin
    case (iadr)
      IX_DIV:   ind_rd = divider[7:0];
      IX_MUL:   ind_rd = {prescale, multiplier, divider[8]};
      IX_CKCTL: ind_rd = {7'h00, cks.enh};
      IX_CKCHK: ind_rd = ~cks.sum;
      IX_STAT:  ind_rd = {5'h00, status};
      IX_MASK:  ind_rd = {5'h00, mask};
      IX_MEAS:  ind_rd = {3'h0, mul_eff};
      default:  ind_rd = 8'h00;
    endcase
  end

  always_comb begin
    case (bus_in.addr)
      OFS_CTRL: next_rd = ctrl;
      OFS_IADR: next_rd = iadr;
      OFS_IDAT: next_rd = ind_rd;
      default:  next_rd = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in)
      rd_data_out <= 8'h00;
    else if (bus_in.rd)
      rd_data_out <= next_rd;
    else
      rd_data_out <= 8'h00;
  end

  role_out_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R1
    (bus_in.wr && bus_in.addr == OFS_CTRL) |=>
      master_role_out == $past(bus_in.wdata[CTRL_ROLE_BIT]))
    else $error("role output differs from written bit");

  auto_master_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R2
    master_role_out |-> !auto_act)
    else $error("automatic rate active in master role");

  auto_sel_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R3
    (bus_in.wr && bus_in.addr == OFS_CTRL) |=>
      auto_act == ($past(bus_in.wdata[CTRL_AUTO_BIT])
                   && !$past(bus_in.wdata[CTRL_ROLE_BIT])))
    else $error("rate select mismatch");

  ind_write_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R4
    (bus_in.wr && bus_in.addr == OFS_IDAT && iadr == IX_MASK) |=>
      mask == $past(bus_in.wdata[ST_W-1:0]))
    else $error("indirect write missed target");

  tick_gap_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R5
    (ref_tick && prescale == 2'h0 && divider == DIV_MIN) |=>
      !ref_tick [*8])
    else $error("reference tick too early");

  div_range_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R6
    divider >= DIV_MIN)
    else $error("divider below range");

  meas_src_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R7
    bit_tick |-> ref_tick)
    else $error("bit tick without reference tick");

  cks_check_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R8
    (wr_ind && iadr == IX_CKCHK && bus_in.wdata == ~cks.sum) |=>
      status[ST_CKOK_BIT])
    else $error("good checksum not flagged");

  sticky_status_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R9
    (status[ST_CKER_BIT] && !(wr_ind && iadr == IX_STAT)) |=>
      status[ST_CKER_BIT])
    else $error("error status lost without clear");

endmodule : lns_node

// ### verif/lns_bus_model.sv
`timescale 1ns/100ps
module lns_bus_model #(
  parameter int GAP_NS = 424320
) (
  input  wire logic start_in,
  output logic      rx_out
);
  // Bus idles recessive high
  initial rx_out = 1'b1;
  always @(posedge start_in) begin
    repeat (2) begin
      rx_out = 1'b0;
      #(GAP_NS / 4);
      rx_out = 1'b1;
      #(GAP_NS - GAP_NS / 4);
    end
  end
endmodule : lns_bus_model

// ### verif/test_lin_node_setup_and_bit_rate.sv
`timescale 1ns/100ps
module test_lin_node_setup_and_bit_rate
  import lns_pkg::*;
;
  logic              ref_clk_in;
  logic              rst_in;
  lns_bus_req_t      bus_in;
  logic [DATA_W-1:0] rd_data_out;
  logic              lin_rx_in;
  logic              bit_tick_out;
  logic              ref_tick_out;
  logic              master_role_out;
  logic              irq_out;
  logic              go;
  int                num_errors;
  int                compares;

  lns_node i_dut (
    .ref_clk_in      (ref_clk_in),
    .rst_in          (rst_in),
    .bus_in          (bus_in),
    .rd_data_out     (rd_data_out),
    .lin_rx_in       (lin_rx_in),
    .bit_tick_out    (bit_tick_out),
    .ref_tick_out    (ref_tick_out),
    .master_role_out (master_role_out),
    .irq_out         (irq_out)
  );

  lns_bus_model i_bus (
    .start_in (go),
    .rx_out   (lin_rx_in)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input string nm, input logic [15:0] s,
                       input logic [15:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus_in <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus_in <= '0;
    #1 d = rd_data_out;
  endtask : rd

  task automatic wi(input logic [7:0] ix, input logic [7:0] d);
    wr(OFS_IADR, ix);
    wr(OFS_IDAT, d);
  endtask : wi

  task automatic expd(input logic [1:0] a, input logic [7:0] e,
                      input string nm);
    logic [7:0] v;
    rd(a, v);
    check(nm, v, e);
  endtask : expd

  task automatic expi(input logic [7:0] ix, input logic [7:0] e,
                      input string nm);
    wr(OFS_IADR, ix);
    expd(OFS_IDAT, e, nm);
  endtask : expi

  task automatic period(input bit sel, output int n);
    int i;
    i = 0;
    do begin
      @(negedge ref_clk_in);
      i++;
    end while ((sel ? ref_tick_out : bit_tick_out) !== 1'b1 && i < 5000);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while ((sel ? ref_tick_out : bit_tick_out) !== 1'b1 && n < 5000);
  endtask : period

  task automatic t_reset();
    expd(OFS_CTRL, CTRL_RST, "ctrl");
    expi(IX_DIV, 8'hC8, "div lo");
    expi(IX_MUL, 8'h00, "mul");
    check("irq", irq_out, 1'b0);
  endtask : t_reset

  task automatic t_map();
    wr(2'h3, 8'h55);
    expd(2'h3, 8'h00, "addr3");
    @(posedge ref_clk_in);
    #1 check("rd idle", rd_data_out, 8'h00);
    expd(OFS_CTRL, 8'h00, "ctrl kept");
    expi(8'h20, 8'h00, "bad index");
    wi(IX_DIV, 8'h10);
    expi(IX_DIV, 8'hC8, "div clamp");
  endtask : t_map

  task automatic rate(input logic [1:0] p, input logic [4:0] m,
                      input logic [8:0] dv);
    int n;
    wr(OFS_CTRL, 8'h00);
    wi(IX_DIV, dv[7:0]);
    wi(IX_MUL, {p, m, dv[8]});
    wr(OFS_CTRL, 8'hC0);
    check("master", master_role_out, 1'b1);
    period(1'b0, n);
    check("bit period", 16'(n), 16'((2 << p) * dv * (m + 1)));
    period(1'b1, n);
    check("ref period", 16'(n), 16'((2 << p) * dv));
  endtask : rate

  task automatic t_auto();
    int i;
    logic [7:0] v;
    wr(OFS_CTRL, 8'h00);
    wi(IX_DIV, 8'h38);
    wi(IX_MUL, 8'h41);
    wi(IX_STAT, 8'h07);
    wr(OFS_CTRL, 8'hA0);
    check("slave", master_role_out, 1'b0);
    go <= 1'b1;
    i = 0;
    do begin
      repeat (1000) @(posedge ref_clk_in);
      wr(OFS_IADR, IX_STAT);
      rd(OFS_IDAT, v);
      i++;
    end while (v[ST_RATE_BIT] !== 1'b1 && i < 40);
    check("rate flag", v[ST_RATE_BIT], 1'b1);
    expi(IX_MEAS, 8'h03, "meas mul");
    check("irq masked", irq_out, 1'b0);
    wi(IX_MASK, 8'h01);
    check("irq on", irq_out, 1'b1);
    wi(IX_STAT, 8'h01);
    check("irq off", irq_out, 1'b0);
    wr(OFS_CTRL, 8'hE0);
    expi(IX_MEAS, 8'h00, "master manual");
    wr(OFS_CTRL, 8'hA0);
  endtask : t_auto

  task automatic t_cks();
    wi(IX_STAT, 8'h07);
    wi(IX_CKCTL, 8'h02);
    wi(IX_CKID, 8'h80);
    wi(IX_CKDAT, 8'h90);
    expi(IX_CKCHK, 8'h6F, "classic");
    wi(IX_CKCHK, 8'h6F);
    expi(IX_STAT, 8'h02, "ck ok");
    wi(IX_STAT, 8'h07);
    wi(IX_CKCTL, 8'h03);
    wi(IX_CKID, 8'h80);
    wi(IX_CKDAT, 8'h90);
    expi(IX_CKCHK, 8'hEE, "enhanced");
    wi(IX_CKCHK, 8'h00);
    expi(IX_STAT, 8'h04, "ck error");
  endtask : t_cks

  task automatic stop_test();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end

  initial begin
    bus_in = '0;
    rst_in = 1'b1;
    go = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_map();
    rate(2'h0, 5'h01, 9'h0C8);
    rate(2'h1, 5'h00, 9'h1FF);
    t_auto();
    t_cks();
    stop_test();
  end
endmodule : test_lin_node_setup_and_bit_rate
